// ==== hs_gate_pkg.sv ====
// Constants, register map and threshold decode for the high-side gate logic.
// Assumes a 10 MHz system clock and a plain strobe-based register port.
package hs_gate_pkg;
  localparam int NUM_CH = 7;
  localparam int MV_W = 16;
  localparam int THR_W = 4;
  localparam int SLEW_W = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IRQ_W = 6;

  // Channel 5 and 7 carry the override; 2, 4, 6 see the boost rail
  localparam logic [NUM_CH-1:0] OVR_CH_MASK = 7'h50;
  localparam logic [NUM_CH-1:0] BOOST_CH_MASK = 7'h2A;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_OVERRIDE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SLEW_RISE = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_SLEW_FALL = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_VDS_THR = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_VSRC_THR = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_VDS_BOOST_THR = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_FBK_SEL = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h28;

  localparam int CTRL_CLK_DIS_BIT = 0;
  localparam int CTRL_BOOST_DIS_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  localparam int IRQ_PREDRIVE_UV = 0;
  localparam int IRQ_FIVE_UV = 1;
  localparam int IRQ_BOOST_UV = 2;
  localparam int IRQ_CLK_LOSS = 3;
  localparam int IRQ_VDS_FAULT = 4;
  localparam int IRQ_DRV_OFF = 5;

  localparam int STAT_CMD_LSB = 0;
  localparam int STAT_VDS_LSB = 7;
  localparam int STAT_VSRC_LSB = 14;
  localparam int STAT_GLOBAL_DRIVER_ENABLE_PIN_BIT = 21;

  localparam logic [SLEW_W-1:0] SLEW_300 = 2'h0;
  localparam logic [SLEW_W-1:0] SLEW_50 = 2'h1;
  localparam logic [SLEW_W-1:0] SLEW_25 = 2'h2;
  localparam logic [SLEW_W-1:0] SLEW_12P5 = 2'h3;

  localparam logic [MV_W-1:0] THR_STEP_FINE_MV = 16'h0064;
  localparam logic [MV_W-1:0] THR_STEP_COARSE_MV = 16'h01F4;
  localparam logic [THR_W-1:0] THR_FINE_BASE = 4'h8;

  // Threshold code to millivolts; unlisted codes read as 0 V
  function automatic logic [MV_W-1:0] thr_to_mv(input logic [THR_W-1:0] code);
    logic [MV_W-1:0] mv;
    mv = 16'h0000;
    if (code >= 4'h1 && code <= 4'h7) begin
      mv = MV_W'(code * THR_STEP_COARSE_MV);
    end else if (code >= 4'h9 && code <= 4'hC) begin
      mv = MV_W'((code - THR_FINE_BASE) * THR_STEP_FINE_MV);
    end
    return mv;
  endfunction
endpackage

// ==== hs_channel_monitor.sv ====
// Per-channel drain-source and source-ground comparators.
// Assumes all voltages are given as millivolt codes on a common scale.
`timescale 1ns/1ns
module hs_channel_monitor #(
  parameter bit HAS_BOOST = 1'b0
) (
  input wire logic [hs_gate_pkg::MV_W-1:0] i_source_mv,
  input wire logic [hs_gate_pkg::MV_W-1:0] i_batt_mv,
  input wire logic [hs_gate_pkg::MV_W-1:0] i_boost_mv,
  input wire logic [hs_gate_pkg::MV_W-1:0] i_ground_mv,
  input wire logic [hs_gate_pkg::THR_W-1:0] i_vds_thr,
  input wire logic [hs_gate_pkg::THR_W-1:0] i_vds_boost_thr,
  input wire logic [hs_gate_pkg::THR_W-1:0] i_vsrc_thr,
  output logic o_vds_batt,
  output logic o_vds_boost,
  output logic o_vsrc
);
  import hs_gate_pkg::*;

  logic [MV_W:0] src_plus_vds;
  logic [MV_W:0] src_plus_boost;
  logic [MV_W:0] gnd_plus_src;

  // Source plus threshold below drain equals source below drain minus it
  always_comb begin
    src_plus_vds = {1'b0, i_source_mv} + {1'b0, thr_to_mv(i_vds_thr)};
    src_plus_boost = {1'b0, i_source_mv} + {1'b0, thr_to_mv(i_vds_boost_thr)};
    gnd_plus_src = {1'b0, i_ground_mv} + {1'b0, thr_to_mv(i_vsrc_thr)};
    o_vds_batt = src_plus_vds < {1'b0, i_batt_mv};
    o_vds_boost = HAS_BOOST && (src_plus_boost < {1'b0, i_boost_mv});
    o_vsrc = {1'b0, i_source_mv} > gnd_plus_src;
  end
endmodule // hs_channel_monitor

// ==== hs_gate_ctrl.sv ====
// High-side gate command logic for seven channels with register port.
// Assumes inputs synchronous to I_CLK_SYS and voltages in millivolt codes.
`timescale 1ns/1ns
module hs_gate_ctrl (
  input wire logic I_CLK_SYS,
  input wire logic I_ARST_N,
  input wire logic [hs_gate_pkg::NUM_CH-1:0] I_CHANNEL_IN,
  input wire logic I_GLOBAL_DRIVER_ENABLE_PIN,
  input wire logic I_PREDRIVE_SUPPLY_UNDERVOLTAGE,
  input wire logic I_FIVE_VOLT_UNDERVOLTAGE,
  input wire logic I_BOOST_UNDERVOLTAGE,
  input wire logic I_CLK_LOCKED,
  input wire logic [hs_gate_pkg::NUM_CH*hs_gate_pkg::MV_W-1:0] I_SOURCE_MV,
  input wire logic [hs_gate_pkg::MV_W-1:0] I_BATTERY_RAIL_MV,
  input wire logic [hs_gate_pkg::MV_W-1:0] I_BOOST_RAIL_MV,
  input wire logic [hs_gate_pkg::MV_W-1:0] I_POWER_GROUND_MV,
  input wire logic I_FBK_SEL_STROBE,
  input wire logic [hs_gate_pkg::NUM_CH-1:0] I_FBK_SEL_BOOST,
  input wire logic [hs_gate_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [hs_gate_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [hs_gate_pkg::DATA_W-1:0] O_RDATA,
  output logic [hs_gate_pkg::NUM_CH-1:0] O_GATE_HIGH,
  output logic [hs_gate_pkg::NUM_CH*hs_gate_pkg::SLEW_W-1:0] O_SLEW_RISE,
  output logic [hs_gate_pkg::NUM_CH*hs_gate_pkg::SLEW_W-1:0] O_SLEW_FALL,
  output logic [hs_gate_pkg::NUM_CH-1:0] O_VDS_BATT_FLAG,
  output logic [hs_gate_pkg::NUM_CH-1:0] O_VDS_BOOST_FLAG,
  output logic [hs_gate_pkg::NUM_CH-1:0] O_VDS_DIAG_FLAG,
  output logic [hs_gate_pkg::NUM_CH-1:0] O_VSRC_FLAG,
  output logic O_IRQ
);
  import hs_gate_pkg::*;

  localparam int SLEW_BITS = NUM_CH * SLEW_W;
  localparam int THR_BITS = NUM_CH * THR_W;

  // Configuration registers
  logic [1:0] ctrl_reg;
  logic [1:0] ctrl_next;
  logic [NUM_CH-1:0] ovr_reg;
  logic [NUM_CH-1:0] ovr_next;
  logic [SLEW_BITS-1:0] slew_rise_reg;
  logic [SLEW_BITS-1:0] slew_rise_next;
  logic [SLEW_BITS-1:0] slew_fall_reg;
  logic [SLEW_BITS-1:0] slew_fall_next;
  logic [THR_BITS-1:0] vds_thr_reg;
  logic [THR_BITS-1:0] vds_thr_next;
  logic [THR_BITS-1:0] vsrc_thr_reg;
  logic [THR_BITS-1:0] vsrc_thr_next;
  logic [THR_BITS-1:0] boost_thr_reg;
  logic [THR_BITS-1:0] boost_thr_next;
  logic [NUM_CH-1:0] fbk_sel_reg;
  logic [NUM_CH-1:0] fbk_sel_next;

  // Interrupt state
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_status_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_mask_next;
  logic [IRQ_W-1:0] cond_prev_reg;
  logic [IRQ_W-1:0] cond_now;
  logic [IRQ_W-1:0] irq_event;
  logic irq_reg;
  logic irq_next;

  // Monitor and read path
  logic [NUM_CH-1:0] vds_batt_raw;
  logic [NUM_CH-1:0] vds_boost_raw;
  logic [NUM_CH-1:0] vsrc_raw;
  logic [NUM_CH-1:0] vds_diag_raw;
  logic [NUM_CH-1:0] vds_batt_reg;
  logic [NUM_CH-1:0] vds_boost_reg;
  logic [NUM_CH-1:0] vds_diag_reg;
  logic [NUM_CH-1:0] vsrc_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // Gating terms
  logic all_off;
  logic [NUM_CH-1:0] enable_ok;
  logic [NUM_CH-1:0] gated_cmd;

  logic wr_ctrl;
  logic wr_ovr;
  logic wr_rise;
  logic wr_fall;
  logic wr_vds;
  logic wr_vsrc;
  logic wr_boost;
  logic wr_irq_stat;
  logic wr_irq_mask;

  // Any global off condition; reset is part of it so no clock is needed
  always_comb begin
    all_off = !I_ARST_N
      || I_PREDRIVE_SUPPLY_UNDERVOLTAGE
      || I_FIVE_VOLT_UNDERVOLTAGE
      || (I_BOOST_UNDERVOLTAGE && ctrl_reg[CTRL_BOOST_DIS_BIT])
      || (!I_CLK_LOCKED && ctrl_reg[CTRL_CLK_DIS_BIT]);
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      // Enable or, on the override channels only, the override bit
      assign enable_ok[ch] = I_GLOBAL_DRIVER_ENABLE_PIN
        || (ovr_reg[ch] && OVR_CH_MASK[ch]);
      // Purely combinational so an off condition acts in the same cycle
      assign gated_cmd[ch] = I_CHANNEL_IN[ch] && enable_ok[ch]
        && !all_off;
      // Drain reference for the single diagnostic result per channel
      assign vds_diag_raw[ch] = (BOOST_CH_MASK[ch] && fbk_sel_reg[ch])
        ? vds_boost_raw[ch] : vds_batt_raw[ch];

      hs_channel_monitor #(
        .HAS_BOOST(BOOST_CH_MASK[ch])
      ) u_mon (
        .i_source_mv(I_SOURCE_MV[ch*MV_W +: MV_W]),
        .i_batt_mv(I_BATTERY_RAIL_MV),
        .i_boost_mv(I_BOOST_RAIL_MV),
        .i_ground_mv(I_POWER_GROUND_MV),
        .i_vds_thr(vds_thr_reg[ch*THR_W +: THR_W]),
        .i_vds_boost_thr(boost_thr_reg[ch*THR_W +: THR_W]),
        .i_vsrc_thr(vsrc_thr_reg[ch*THR_W +: THR_W]),
        .o_vds_batt(vds_batt_raw[ch]),
        .o_vds_boost(vds_boost_raw[ch]),
        .o_vsrc(vsrc_raw[ch])
      );
    end
  endgenerate

  // Gate drive follows the gated command without a register stage
  assign O_GATE_HIGH = gated_cmd;

  // Address decode for writes
  always_comb begin
    wr_ctrl = 1'b0;
    wr_ovr = 1'b0;
    wr_rise = 1'b0;
    wr_fall = 1'b0;
    wr_vds = 1'b0;
    wr_vsrc = 1'b0;
    wr_boost = 1'b0;
    wr_irq_stat = 1'b0;
    wr_irq_mask = 1'b0;
    if (I_WR) begin
      if (I_ADDR == ADDR_CTRL) begin
        wr_ctrl = 1'b1;
      end else if (I_ADDR == ADDR_OVERRIDE) begin
        wr_ovr = 1'b1;
      end else if (I_ADDR == ADDR_SLEW_RISE) begin
        wr_rise = 1'b1;
      end else if (I_ADDR == ADDR_SLEW_FALL) begin
        wr_fall = 1'b1;
      end else if (I_ADDR == ADDR_VDS_THR) begin
        wr_vds = 1'b1;
      end else if (I_ADDR == ADDR_VSRC_THR) begin
        wr_vsrc = 1'b1;
      end else if (I_ADDR == ADDR_VDS_BOOST_THR) begin
        wr_boost = 1'b1;
      end else if (I_ADDR == ADDR_IRQ_STATUS) begin
        wr_irq_stat = 1'b1;
      end else if (I_ADDR == ADDR_IRQ_MASK) begin
        wr_irq_mask = 1'b1;
      end
    end
  end

  // Configuration next values
  always_comb begin
    ctrl_next = ctrl_reg;
    ovr_next = ovr_reg;
    slew_rise_next = slew_rise_reg;
    slew_fall_next = slew_fall_reg;
    vds_thr_next = vds_thr_reg;
    vsrc_thr_next = vsrc_thr_reg;
    boost_thr_next = boost_thr_reg;
    fbk_sel_next = fbk_sel_reg;
    if (wr_ctrl) begin
      ctrl_next = I_WDATA[1:0];
    end
    if (wr_ovr) begin
      ovr_next = I_WDATA[NUM_CH-1:0] & OVR_CH_MASK;
    end
    if (wr_rise) begin
      slew_rise_next = I_WDATA[SLEW_BITS-1:0];
      // Falling edge follows so the absolute slew stays matched
      slew_fall_next = I_WDATA[SLEW_BITS-1:0];
    end else if (wr_fall) begin
      slew_fall_next = I_WDATA[SLEW_BITS-1:0];
    end
    if (wr_vds) begin
      vds_thr_next = I_WDATA[THR_BITS-1:0];
    end
    if (wr_vsrc) begin
      vsrc_thr_next = I_WDATA[THR_BITS-1:0];
    end
    if (wr_boost) begin
      boost_thr_next = I_WDATA[THR_BITS-1:0] & {NUM_CH{4'hF}};
    end
    if (I_FBK_SEL_STROBE) begin
      fbk_sel_next = I_FBK_SEL_BOOST & BOOST_CH_MASK;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ctrl_reg <= CTRL_RESET;
      ovr_reg <= '0;
      slew_rise_reg <= '0;
      slew_fall_reg <= '0;
      vds_thr_reg <= '0;
      vsrc_thr_reg <= '0;
      boost_thr_reg <= '0;
      fbk_sel_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      ovr_reg <= ovr_next;
      slew_rise_reg <= slew_rise_next;
      slew_fall_reg <= slew_fall_next;
      vds_thr_reg <= vds_thr_next;
      vsrc_thr_reg <= vsrc_thr_next;
      boost_thr_reg <= boost_thr_next;
      fbk_sel_reg <= fbk_sel_next;
    end
  end

  // Slew codes go straight to the analog drive stages
  assign O_SLEW_RISE = slew_rise_reg;
  assign O_SLEW_FALL = slew_fall_reg;

  // Events are rising edges of the shutdown conditions and of the OR of all VDS diagnostic flags
  always_comb begin
    cond_now = '0;
    cond_now[IRQ_PREDRIVE_UV] = I_PREDRIVE_SUPPLY_UNDERVOLTAGE;
    cond_now[IRQ_FIVE_UV] = I_FIVE_VOLT_UNDERVOLTAGE;
    cond_now[IRQ_BOOST_UV] = I_BOOST_UNDERVOLTAGE
      && ctrl_reg[CTRL_BOOST_DIS_BIT];
    cond_now[IRQ_CLK_LOSS] = !I_CLK_LOCKED && ctrl_reg[CTRL_CLK_DIS_BIT];
    cond_now[IRQ_VDS_FAULT] = |vds_diag_reg;
    cond_now[IRQ_DRV_OFF] = !I_GLOBAL_DRIVER_ENABLE_PIN;
    irq_event = cond_now & ~cond_prev_reg;
  end

  // Write one to clear; a new event in the same cycle keeps the bit set
  always_comb begin
    irq_status_next = irq_status_reg;
    irq_mask_next = irq_mask_reg;
    if (wr_irq_stat) begin
      irq_status_next = irq_status_reg & ~I_WDATA[IRQ_W-1:0];
    end
    irq_status_next = irq_status_next | irq_event;
    if (wr_irq_mask) begin
      irq_mask_next = I_WDATA[IRQ_W-1:0];
    end
    irq_next = |(irq_status_next & irq_mask_next);
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      irq_status_reg <= '0;
      irq_mask_reg <= '0;
      // Enable taken as already low, so release gives no false fall event
      cond_prev_reg <= IRQ_W'(1 << IRQ_DRV_OFF);
      irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      cond_prev_reg <= cond_now;
      irq_reg <= irq_next;
    end
  end

  assign O_IRQ = irq_reg;

  // Comparator results registered before leaving the block
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      vds_batt_reg <= '0;
      vds_boost_reg <= '0;
      vds_diag_reg <= '0;
      vsrc_reg <= '0;
    end else begin
      vds_batt_reg <= vds_batt_raw;
      vds_boost_reg <= vds_boost_raw;
      vds_diag_reg <= vds_diag_raw;
      vsrc_reg <= vsrc_raw;
    end
  end

  assign O_VDS_BATT_FLAG = vds_batt_reg;
  assign O_VDS_BOOST_FLAG = vds_boost_reg;
  assign O_VDS_DIAG_FLAG = vds_diag_reg;
  assign O_VSRC_FLAG = vsrc_reg;

  // Read mux; data valid only in the cycle after the strobe
  always_comb begin
    rdata_next = '0;
    if (I_RD) begin
      if (I_ADDR == ADDR_CTRL) begin
        rdata_next[1:0] = ctrl_reg;
      end else if (I_ADDR == ADDR_OVERRIDE) begin
        rdata_next[NUM_CH-1:0] = ovr_reg;
      end else if (I_ADDR == ADDR_SLEW_RISE) begin
        rdata_next[SLEW_BITS-1:0] = slew_rise_reg;
      end else if (I_ADDR == ADDR_SLEW_FALL) begin
        rdata_next[SLEW_BITS-1:0] = slew_fall_reg;
      end else if (I_ADDR == ADDR_VDS_THR) begin
        rdata_next[THR_BITS-1:0] = vds_thr_reg;
      end else if (I_ADDR == ADDR_VSRC_THR) begin
        rdata_next[THR_BITS-1:0] = vsrc_thr_reg;
      end else if (I_ADDR == ADDR_VDS_BOOST_THR) begin
        rdata_next[THR_BITS-1:0] = boost_thr_reg;
      end else if (I_ADDR == ADDR_FBK_SEL) begin
        rdata_next[NUM_CH-1:0] = fbk_sel_reg;
      end else if (I_ADDR == ADDR_STATUS) begin
        rdata_next[STAT_CMD_LSB +: NUM_CH] = gated_cmd;
        rdata_next[STAT_VDS_LSB +: NUM_CH] = vds_diag_reg;
        rdata_next[STAT_VSRC_LSB +: NUM_CH] = vsrc_reg;
        rdata_next[STAT_GLOBAL_DRIVER_ENABLE_PIN_BIT] = I_GLOBAL_DRIVER_ENABLE_PIN;
      end else if (I_ADDR == ADDR_IRQ_STATUS) begin
        rdata_next[IRQ_W-1:0] = irq_status_reg;
      end else if (I_ADDR == ADDR_IRQ_MASK) begin
        rdata_next[IRQ_W-1:0] = irq_mask_reg;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign O_RDATA = rdata_reg;
endmodule // hs_gate_ctrl

// ==== hs_fet_model.sv ====
// Behavioural model of the seven external high-side MOSFETs.
// Assumes gate drive from the block and rails given in millivolts.
`timescale 1ns/1ns
module hs_fet_model (
  input wire logic [hs_gate_pkg::NUM_CH-1:0] i_gate,
  input wire logic [hs_gate_pkg::MV_W-1:0] i_batt_mv,
  input wire logic [hs_gate_pkg::MV_W-1:0] i_drop_mv,
  input wire logic [hs_gate_pkg::MV_W-1:0] i_fw_mv,
  output logic [hs_gate_pkg::NUM_CH*hs_gate_pkg::MV_W-1:0] o_source_mv
);
  import hs_gate_pkg::*;
  // On: source one drop below battery; off: freewheel element level
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      o_source_mv[i*MV_W +: MV_W] = i_gate[i] ?
        i_batt_mv - i_drop_mv : i_fw_mv;
    end
  end
endmodule // hs_fet_model

// ==== hs_gate_ctrl_assertions.sv ====
// Port checker for hs_gate_ctrl.
// Assumes binding to the top module; sees its ports only.
`timescale 1ns/1ns
module hs_gate_ctrl_assertions (
  input wire logic I_CLK_SYS,
  input wire logic I_ARST_N,
  input wire logic [hs_gate_pkg::NUM_CH-1:0] I_CHANNEL_IN,
  input wire logic I_GLOBAL_DRIVER_ENABLE_PIN,
  input wire logic I_PREDRIVE_SUPPLY_UNDERVOLTAGE,
  input wire logic I_FIVE_VOLT_UNDERVOLTAGE,
  input wire logic I_BOOST_UNDERVOLTAGE,
  input wire logic I_CLK_LOCKED,
  input wire logic I_FBK_SEL_STROBE,
  input wire logic [hs_gate_pkg::NUM_CH-1:0] I_FBK_SEL_BOOST,
  input wire logic [hs_gate_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [hs_gate_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic [hs_gate_pkg::NUM_CH-1:0] O_GATE_HIGH,
  input wire logic [hs_gate_pkg::NUM_CH*hs_gate_pkg::SLEW_W-1:0] O_SLEW_RISE,
  input wire logic [hs_gate_pkg::NUM_CH*hs_gate_pkg::SLEW_W-1:0] O_SLEW_FALL,
  input wire logic [hs_gate_pkg::NUM_CH-1:0] O_VDS_BATT_FLAG,
  input wire logic [hs_gate_pkg::NUM_CH-1:0] O_VDS_BOOST_FLAG,
  input wire logic [hs_gate_pkg::NUM_CH-1:0] O_VDS_DIAG_FLAG
);
  import hs_gate_pkg::*;
  logic [NUM_CH*SLEW_W-1:0] wd_low;
  assign wd_low = I_WDATA[NUM_CH*SLEW_W-1:0];
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_ARST_N);
  sequence sel_boost_s;
    I_FBK_SEL_STROBE && I_FBK_SEL_BOOST[1];
  endsequence
  sequence sel_hold_s;
    !I_FBK_SEL_STROBE;
  endsequence
  sequence rise_wr_s;
    I_WR && I_ADDR == ADDR_SLEW_RISE;
  endsequence
  sequence fall_wr_s;
    I_WR && I_ADDR == ADDR_SLEW_FALL;
  endsequence
  supply_off_a: assert property (
    (I_PREDRIVE_SUPPLY_UNDERVOLTAGE || I_FIVE_VOLT_UNDERVOLTAGE)
    |-> O_GATE_HIGH == 7'h00) else $error("gate on in undervoltage");
  enable_off_a: assert property (
    !I_GLOBAL_DRIVER_ENABLE_PIN |-> (O_GATE_HIGH & ~OVR_CH_MASK) == 7'h00)
    else $error("gate on without enable");
  gate_follow_a: assert property (
    (I_GLOBAL_DRIVER_ENABLE_PIN && !I_PREDRIVE_SUPPLY_UNDERVOLTAGE &&
    !I_FIVE_VOLT_UNDERVOLTAGE && !I_BOOST_UNDERVOLTAGE && I_CLK_LOCKED)
    |-> O_GATE_HIGH == I_CHANNEL_IN) else $error("gate not following input");
  input_gate_a: assert property (
    (O_GATE_HIGH & ~I_CHANNEL_IN) == 7'h00) else $error("gate without input");
  rise_copy_a: assert property (
    rise_wr_s |=> O_SLEW_RISE == $past(wd_low) && O_SLEW_FALL == O_SLEW_RISE)
    else $error("rise write not copied");
  fall_only_a: assert property (
    fall_wr_s |=> $stable(O_SLEW_RISE) && O_SLEW_FALL == $past(wd_low))
    else $error("fall write disturbed rise");
  boost_chan_a: assert property (
    (O_VDS_BOOST_FLAG & ~BOOST_CH_MASK) == 7'h00)
    else $error("boost flag on odd channel");
  batt_diag_a: assert property (
    (O_VDS_DIAG_FLAG & ~BOOST_CH_MASK) == (O_VDS_BATT_FLAG & ~BOOST_CH_MASK))
    else $error("odd channel diag not battery");
  fbk_diag_a: assert property (
    sel_boost_s ##1 sel_hold_s |=> O_VDS_DIAG_FLAG[1] == O_VDS_BOOST_FLAG[1])
    else $error("diag not boost after select");
endmodule // hs_gate_ctrl_assertions

// ==== hs_gate_ctrl_bench.sv ====
// Self-checking bench for hs_gate_ctrl with MOSFET models on the gates.
// Assumes the register map and latencies of hs_gate_pkg.
`timescale 1ns/1ns
module hs_gate_ctrl_bench;
  import hs_gate_pkg::*;
  localparam logic [3:0] CODES [12] = '{4'h0, 4'h9, 4'hA, 4'hB, 4'hC,
    4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
  localparam logic [15:0] MVS [12] = '{16'h0000, 16'h0064, 16'h00C8,
    16'h012C, 16'h0190, 16'h01F4, 16'h03E8, 16'h05DC, 16'h07D0, 16'h09C4,
    16'h0BB8, 16'h0DAC};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic en = 1'b0, uvp = 1'b0, uv5 = 1'b0, buv = 1'b0, lock = 1'b1;
  logic wr = 1'b0, rd = 1'b0, fstb = 1'b0, irq;
  logic [NUM_CH-1:0] ch_in = 7'h00, fsel = 7'h00;
  logic [NUM_CH-1:0] gate, vbat, vbst, vdiag, vsrc;
  logic [MV_W-1:0] batt = 16'h2EE0, boost = 16'h4E20, gnd = 16'h0000;
  logic [MV_W-1:0] drop = 16'h0000, fw = 16'h0000;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0, rdata;
  logic [NUM_CH*MV_W-1:0] src;
  logic [NUM_CH*SLEW_W-1:0] srise, sfall;
  int fail_count = 0, comparisons = 0;
  always #50 clk = ~clk;
  hs_gate_ctrl DUT (.I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_CHANNEL_IN(ch_in),
    .I_GLOBAL_DRIVER_ENABLE_PIN(en), .I_PREDRIVE_SUPPLY_UNDERVOLTAGE(uvp),
    .I_FIVE_VOLT_UNDERVOLTAGE(uv5), .I_BOOST_UNDERVOLTAGE(buv),
    .I_CLK_LOCKED(lock), .I_SOURCE_MV(src), .I_BATTERY_RAIL_MV(batt),
    .I_BOOST_RAIL_MV(boost), .I_POWER_GROUND_MV(gnd),
    .I_FBK_SEL_STROBE(fstb), .I_FBK_SEL_BOOST(fsel), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .O_GATE_HIGH(gate), .O_SLEW_RISE(srise), .O_SLEW_FALL(sfall),
    .O_VDS_BATT_FLAG(vbat), .O_VDS_BOOST_FLAG(vbst),
    .O_VDS_DIAG_FLAG(vdiag), .O_VSRC_FLAG(vsrc), .O_IRQ(irq));
  hs_fet_model fets (.i_gate(gate), .i_batt_mv(batt), .i_drop_mv(drop),
    .i_fw_mv(fw), .o_source_mv(src));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cg(input logic [NUM_CH-1:0] e);
    #1 chk("gate", 32'(e), 32'(gate));
  endtask
  task automatic sett();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask
  task automatic t_enable();
    wrr(ADDR_OVERRIDE, 32'h000000FF);
    rdc("override", ADDR_OVERRIDE, 32'h00000050);
    wrr(ADDR_OVERRIDE, 32'h0);
    @(posedge clk);
    ch_in <= 7'h7F;
    en <= 1'b1;
    cg(7'h7F);
    @(posedge clk);
    en <= 1'b0;
    cg(7'h00);
    wrr(ADDR_OVERRIDE, 32'h50);
    cg(7'h50);
    @(posedge clk);
    ch_in <= 7'h3F;
    cg(7'h10);
  endtask
  task automatic t_uv();
    @(posedge clk);
    ch_in <= 7'h7F;
    uvp <= 1'b1;
    cg(7'h00);
    @(posedge clk);
    en <= 1'b1;
    cg(7'h00);
    @(posedge clk);
    uvp <= 1'b0;
    uv5 <= 1'b1;
    cg(7'h00);
    @(posedge clk);
    en <= 1'b0;
    cg(7'h00);
    @(posedge clk);
    uv5 <= 1'b0;
    en <= 1'b1;
    cg(7'h7F);
  endtask
  task automatic t_bc();
    @(posedge clk);
    buv <= 1'b1;
    cg(7'h7F);
    wrr(ADDR_CTRL, 32'h2);
    cg(7'h00);
    @(posedge clk);
    buv <= 1'b0;
    lock <= 1'b0;
    cg(7'h7F);
    wrr(ADDR_CTRL, 32'h3);
    cg(7'h00);
    @(posedge clk);
    lock <= 1'b1;
    cg(7'h7F);
    wrr(ADDR_CTRL, 32'h0);
  endtask
  task automatic t_slew();
    logic [13:0] v;
    for (int c = 0; c < 4; c++) begin
      v = {7{c[1:0]}};
      wrr(ADDR_SLEW_RISE, 32'(v));
      #1 chk("rise", 32'(v), 32'(srise));
      chk("fall copy", 32'(v), 32'(sfall));
    end
    wrr(ADDR_SLEW_FALL, 32'h1B1B);
    #1 chk("fall", 32'h1B1B, 32'(sfall));
    chk("rise kept", 32'h3FFF, 32'(srise));
    rdc("rise reg", ADDR_SLEW_RISE, 32'h3FFF);
  endtask
  task automatic t_thr();
    logic [27:0] t;
    for (int i = 0; i < 12; i++) begin
      t = {7{CODES[i]}};
      wrr(ADDR_VDS_THR, 32'(t));
      wrr(ADDR_VSRC_THR, 32'(t));
      wrr(ADDR_VDS_BOOST_THR, 32'(t));
      @(posedge clk);
      ch_in <= 7'h7F;
      drop <= MVS[i];
      sett();
      chk("vds equal", 32'h0, 32'(vbat));
      chk("vds boost", 32'h2A, 32'(vbst));
      @(posedge clk);
      drop <= MVS[i] + 16'h0032;
      sett();
      chk("vds over", 32'h7F, 32'(vbat));
      @(posedge clk);
      ch_in <= 7'h00;
      fw <= MVS[i];
      sett();
      chk("vsrc equal", 32'h0, 32'(vsrc));
      @(posedge clk);
      fw <= MVS[i] + 16'h0032;
      sett();
      chk("vsrc over", 32'h7F, 32'(vsrc));
    end
  endtask
  task automatic t_fbk();
    @(posedge clk);
    ch_in <= 7'h7F;
    drop <= 16'h0DAC;
    fstb <= 1'b1;
    fsel <= 7'h7F;
    @(posedge clk);
    fstb <= 1'b0;
    sett();
    chk("diag boost", 32'h2A, 32'(vdiag));
    rdc("fbk sel", ADDR_FBK_SEL, 32'h2A);
    @(posedge clk);
    fstb <= 1'b1;
    fsel <= 7'h00;
    @(posedge clk);
    fstb <= 1'b0;
    sett();
    chk("diag batt", 32'h0, 32'(vdiag));
  endtask
  task automatic t_irq();
    @(posedge clk);
    ch_in <= 7'h00;
    sett();
    wrr(ADDR_IRQ_STATUS, 32'h3F);
    wrr(ADDR_IRQ_MASK, 32'h1);
    @(posedge clk);
    uvp <= 1'b1;
    @(posedge clk);
    uvp <= 1'b0;
    #1 chk("irq set", 32'h1, 32'(irq));
    rdc("irq status", ADDR_IRQ_STATUS, 32'h1);
    wrr(ADDR_IRQ_STATUS, 32'h1);
    #1 chk("irq clear", 32'h0, 32'(irq));
    wrr(ADDR_IRQ_MASK, 32'h0);
    @(posedge clk);
    uv5 <= 1'b1;
    @(posedge clk);
    uv5 <= 1'b0;
    #1 chk("irq masked", 32'h0, 32'(irq));
    rdc("irq status 5v", ADDR_IRQ_STATUS, 32'h2);
    wrr(ADDR_IRQ_STATUS, 32'h3F);
    wrr(ADDR_CTRL, 32'h3);
    @(posedge clk);
    buv <= 1'b1;
    lock <= 1'b0;
    en <= 1'b0;
    @(posedge clk);
    buv <= 1'b0;
    lock <= 1'b1;
    en <= 1'b1;
    rdc("irq status other", ADDR_IRQ_STATUS, 32'h2C);
    wrr(ADDR_CTRL, 32'h0);
    rdc("status", ADDR_STATUS, 32'h003FFF80);
    rdc("unmapped", 8'hFC, 32'h0);
  endtask
  task automatic t_reset();
    @(posedge clk);
    ch_in <= 7'h7F;
    #30 arst_n = 1'b0;
    cg(7'h00);
    @(posedge clk);
    arst_n <= 1'b1;
    rdc("ctrl after reset", ADDR_CTRL, 32'h0);
    rdc("override after reset", ADDR_OVERRIDE, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rdc("ctrl reset", ADDR_CTRL, 32'h0);
    t_enable();
    t_uv();
    t_bc();
    t_slew();
    t_thr();
    t_fbk();
    t_irq();
    t_reset();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule // hs_gate_ctrl_bench
bind hs_gate_ctrl hs_gate_ctrl_assertions u_chk (.I_CLK_SYS, .I_ARST_N,
  .I_CHANNEL_IN, .I_GLOBAL_DRIVER_ENABLE_PIN, .I_PREDRIVE_SUPPLY_UNDERVOLTAGE,
  .I_FIVE_VOLT_UNDERVOLTAGE, .I_BOOST_UNDERVOLTAGE, .I_CLK_LOCKED,
  .I_FBK_SEL_STROBE, .I_FBK_SEL_BOOST, .I_ADDR, .I_WDATA, .I_WR,
  .O_GATE_HIGH, .O_SLEW_RISE, .O_SLEW_FALL, .O_VDS_BATT_FLAG,
  .O_VDS_BOOST_FLAG, .O_VDS_DIAG_FLAG);
